/* core/gp_timers_pkg.sv */
// Register map, field positions and constants for the two general purpose timers
package gp_timers_pkg;
  // Byte offsets of the registers
  localparam logic [7:0] OFS_T0_RELOAD  = 8'h00;
  localparam logic [7:0] OFS_T0_COUNT   = 8'h04;
  localparam logic [7:0] OFS_T0_CONTROL = 8'h08;
  localparam logic [7:0] OFS_T0_CLEAR   = 8'h0c;
  localparam logic [7:0] OFS_T1_RELOAD  = 8'h20;
  localparam logic [7:0] OFS_T1_COUNT   = 8'h24;
  localparam logic [7:0] OFS_T1_CONTROL = 8'h28;
  localparam logic [7:0] OFS_T1_CLEAR   = 8'h2c;
  localparam logic [7:0] OFS_T1_CAPTURE = 8'h30;
  localparam logic [7:0] OFS_STATUS     = 8'h34;

  // Control field positions
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_PERIODIC = 6;
  localparam int BIT_UP       = 8;
  localparam int BIT_CAP_EN   = 17;
  localparam int EVT_LSB      = 12;
  localparam int EVT_MSB      = 16;
  localparam int CSEL_LSB     = 9;
  localparam int CSEL_MSB     = 11;
  localparam int FMT_LSB      = 4;
  localparam int FMT_MSB      = 5;
  localparam int T0_PRE_LSB   = 2;
  localparam int T0_PRE_MSB   = 3;
  localparam int T1_PRE_LSB   = 0;
  localparam int T1_PRE_MSB   = 3;

  // Writable bit masks; reserved bits read zero
  localparam logic [31:0] T0_CTRL_MASK  = 32'h0000_00cc;
  localparam logic [31:0] T1_CTRL_MASK  = 32'h0003_ffff;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // Event number n maps to interrupt source n + 2
  localparam int EVT_OFFSET = 2;
  localparam int NUM_IRQ_SRC = 34;

  // Prescale codes
  localparam logic [1:0] T0_PRE_16   = 2'b01;
  localparam logic [1:0] T0_PRE_256  = 2'b10;
  localparam logic [3:0] T1_PRE_16   = 4'b0100;
  localparam logic [3:0] T1_PRE_256  = 4'b1000;
  localparam logic [3:0] T1_PRE_32K  = 4'b1111;

  // Clock select codes
  localparam logic [2:0] CSEL_CORE = 3'b000;
  localparam logic [2:0] CSEL_OSC  = 3'b001;
  localparam logic [2:0] CSEL_PINA = 3'b010;
  localparam logic [2:0] CSEL_PINB = 3'b011;

  // Format codes
  localparam logic [1:0] FMT_BIN    = 2'b00;
  localparam logic [1:0] FMT_HMS23  = 2'b10;
  localparam logic [1:0] FMT_HMS255 = 2'b11;

  // Time-of-day field limits (hours 31:24, min 23:16, sec 15:8, hundredths 7:0)
  localparam logic [7:0] HUND_MAX = 8'd99;
  localparam logic [7:0] SEC_MAX  = 8'd59;
  localparam logic [7:0] MIN_MAX  = 8'd59;
  localparam logic [7:0] HR23_MAX = 8'd23;
  localparam logic [7:0] HR255_MAX = 8'd255;

  // AHB transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
endpackage

/* core/gp_timers.sv */
// Two general purpose timers with an AHB-Lite register slave
`timescale 1ns/10ps
module gp_timers
#(
  parameter int T0_WIDTH = 16,
  parameter int T1_WIDTH = 32
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        osc_32k,
  input  wire logic        ext_clock_pin_a,
  input  wire logic        ext_clock_pin_b,
  input  wire logic [31:0] irq_sources,
  output logic             timer0_irq,
  output logic             timer1_irq
);
  import gp_timers_pkg::*;

  logic [T0_WIDTH-1:0] t0_reload_q;
  logic [T0_WIDTH-1:0] t0_count_q;
  logic [31:0]         t0_ctrl_q;
  logic [T1_WIDTH-1:0] t1_reload_q;
  logic [T1_WIDTH-1:0] t1_count_q;
  logic [T1_WIDTH-1:0] t1_cap_q;
  logic [31:0]         t1_ctrl_q;
  logic [7:0]          t0_pre_q;
  logic [14:0]         t1_pre_q;
  logic                t0_irq_q;
  logic                t1_irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins, the slow oscillator and the interrupt sources
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [31:0] src_s1_q;
  logic [31:0] src_s2_q;
  logic [31:0] src_d_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else if (clk_en) begin
      sync1_q <= {ext_clock_pin_b, ext_clock_pin_a, osc_32k};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_s1_q <= 32'h0;
      src_s2_q <= 32'h0;
      src_d_q  <= 32'h0;
    end else if (clk_en) begin
      src_s1_q <= irq_sources;
      src_s2_q <= src_s1_q;
      src_d_q  <= src_s2_q;
    end
  end

  logic [2:0] rise;
  assign rise = sync2_q & ~sync3_q;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, writes land in the data phase
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       accept;

  assign accept    = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
    end else if (clk_en) begin
      wr_pend_q <= accept && hwrite;
      if (accept) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  logic wr_t0_reload;
  logic wr_t0_ctrl;
  logic wr_t0_clear;
  logic wr_t1_reload;
  logic wr_t1_ctrl;
  logic wr_t1_clear;

  assign wr_t0_reload = wr_pend_q && wr_addr_q == OFS_T0_RELOAD;
  assign wr_t0_ctrl   = wr_pend_q && wr_addr_q == OFS_T0_CONTROL;
  assign wr_t0_clear  = wr_pend_q && wr_addr_q == OFS_T0_CLEAR;
  assign wr_t1_reload = wr_pend_q && wr_addr_q == OFS_T1_RELOAD;
  assign wr_t1_ctrl   = wr_pend_q && wr_addr_q == OFS_T1_CONTROL;
  assign wr_t1_clear  = wr_pend_q && wr_addr_q == OFS_T1_CLEAR;

  // Read data registered at the address phase so it stands in the data phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (haddr[7:0])
      OFS_T0_RELOAD:  rd_mux = 32'(t0_reload_q);
      OFS_T0_COUNT:   rd_mux = 32'(t0_count_q);
      OFS_T0_CONTROL: rd_mux = t0_ctrl_q;
      OFS_T1_RELOAD:  rd_mux = 32'(t1_reload_q);
      OFS_T1_COUNT:   rd_mux = 32'(t1_count_q);
      OFS_T1_CONTROL: rd_mux = t1_ctrl_q;
      OFS_T1_CAPTURE: rd_mux = 32'(t1_cap_q);
      OFS_STATUS:     rd_mux = {30'h0, t1_irq_q, t0_irq_q};
      default:        rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (clk_en && accept && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and load registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t0_ctrl_q   <= CTRL_RESET;
      t0_reload_q <= '0;
    end else if (clk_en) begin
      if (wr_t0_ctrl) begin
        t0_ctrl_q <= hwdata & T0_CTRL_MASK;
      end
      if (wr_t0_reload) begin
        t0_reload_q <= hwdata[T0_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_ctrl_q   <= CTRL_RESET;
      t1_reload_q <= '0;
    end else if (clk_en) begin
      if (wr_t1_ctrl) begin
        t1_ctrl_q <= hwdata & T1_CTRL_MASK;
      end
      if (wr_t1_reload) begin
        t1_reload_q <= hwdata[T1_WIDTH-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer0: core clock prescaled, 16-bit down counter
  logic [7:0] t0_div;
  logic       t0_tick;
  logic       t0_en;

  assign t0_en = t0_ctrl_q[BIT_ENABLE];
  always_comb begin
    unique case (t0_ctrl_q[T0_PRE_MSB:T0_PRE_LSB])
      T0_PRE_16:  t0_div = 8'h0f;
      T0_PRE_256: t0_div = 8'hff;
      default:    t0_div = 8'h00;
    endcase
  end
  assign t0_tick = t0_en && (t0_pre_q >= t0_div);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t0_pre_q <= 8'h0;
    end else if (clk_en) begin
      if (!t0_en || t0_tick) begin
        t0_pre_q <= 8'h0;
      end else begin
        t0_pre_q <= t0_pre_q + 8'h1;
      end
    end
  end

  logic t0_term;
  assign t0_term = t0_tick && t0_count_q == '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t0_count_q <= '1;
    end else if (clk_en && t0_tick) begin
      if (t0_count_q == '0) begin
        if (t0_ctrl_q[BIT_PERIODIC]) begin
          t0_count_q <= t0_reload_q;
        end else begin
          t0_count_q <= '1;
        end
      end else begin
        t0_count_q <= t0_count_q - 1'b1;
      end
    end
  end

  // Terminal count wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t0_irq_q <= 1'b0;
    end else if (clk_en) begin
      if (t0_term) begin
        t0_irq_q <= 1'b1;
      end else if (wr_t0_clear) begin
        t0_irq_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer1: selectable source, prescaler, binary or time-of-day format
  logic        t1_en;
  logic        t1_up;
  logic        src_edge;
  logic [14:0] t1_div;
  logic        t1_tick;
  logic [1:0]  fmt;
  logic        hms;

  assign t1_en = t1_ctrl_q[BIT_ENABLE];
  assign t1_up = t1_ctrl_q[BIT_UP];
  assign fmt   = t1_ctrl_q[FMT_MSB:FMT_LSB];
  assign hms   = (fmt == FMT_HMS23) || (fmt == FMT_HMS255);

  always_comb begin
    unique case (t1_ctrl_q[CSEL_MSB:CSEL_LSB])
      CSEL_OSC:  src_edge = rise[0];
      CSEL_PINA: src_edge = rise[1];
      CSEL_PINB: src_edge = rise[2];
      default:   src_edge = 1'b1;
    endcase
  end

  // Unlisted prescale codes divide by one
  always_comb begin
    unique case (t1_ctrl_q[T1_PRE_MSB:T1_PRE_LSB])
      T1_PRE_16:  t1_div = 15'h000f;
      T1_PRE_256: t1_div = 15'h00ff;
      T1_PRE_32K: t1_div = 15'h7fff;
      default:    t1_div = 15'h0000;
    endcase
  end
  assign t1_tick = t1_en && src_edge && (t1_pre_q >= t1_div);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_pre_q <= 15'h0;
    end else if (clk_en) begin
      if (!t1_en || t1_tick) begin
        t1_pre_q <= 15'h0;
      end else if (src_edge) begin
        t1_pre_q <= t1_pre_q + 15'h1;
      end
    end
  end

  // Time-of-day fields
  logic [7:0] hr;
  logic [7:0] mn;
  logic [7:0] sc;
  logic [7:0] hu;
  logic [7:0] hr_max;
  logic [31:0] hms_step;
  logic [31:0] hms_full;

  assign {hr, mn, sc, hu} = t1_count_q;
  assign hr_max   = (fmt == FMT_HMS23) ? HR23_MAX : HR255_MAX;
  assign hms_full = {hr_max, MIN_MAX, SEC_MAX, HUND_MAX};

  always_comb begin
    hms_step = t1_count_q;
    if (t1_up) begin
      if (hu < HUND_MAX) begin
        hms_step = {hr, mn, sc, hu + 8'h1};
      end else if (sc < SEC_MAX) begin
        hms_step = {hr, mn, sc + 8'h1, 8'h0};
      end else if (mn < MIN_MAX) begin
        hms_step = {hr, mn + 8'h1, 16'h0};
      end else begin
        hms_step = {hr + 8'h1, 24'h0};
      end
    end else begin
      if (hu != 8'h0) begin
        hms_step = {hr, mn, sc, hu - 8'h1};
      end else if (sc != 8'h0) begin
        hms_step = {hr, mn, sc - 8'h1, HUND_MAX};
      end else if (mn != 8'h0) begin
        hms_step = {hr, mn - 8'h1, SEC_MAX, HUND_MAX};
      end else begin
        hms_step = {hr - 8'h1, MIN_MAX, SEC_MAX, HUND_MAX};
      end
    end
  end

  logic [T1_WIDTH-1:0] t1_min;
  logic [T1_WIDTH-1:0] t1_max;
  logic                t1_at_end;
  logic                t1_term;

  assign t1_min    = '0;
  assign t1_max    = hms ? T1_WIDTH'(hms_full) : '1;
  assign t1_at_end = t1_up ? (t1_count_q == t1_max) : (t1_count_q == t1_min);
  assign t1_term   = t1_tick && t1_at_end;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_count_q <= '1;
    end else if (clk_en && t1_tick) begin
      if (t1_at_end) begin
        if (t1_ctrl_q[BIT_PERIODIC]) begin
          t1_count_q <= t1_reload_q;
        end else begin
          t1_count_q <= t1_up ? t1_min : t1_max;
        end
      end else if (hms) begin
        t1_count_q <= T1_WIDTH'(hms_step);
      end else if (t1_up) begin
        t1_count_q <= t1_count_q + 1'b1;
      end else begin
        t1_count_q <= t1_count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_irq_q <= 1'b0;
    end else if (clk_en) begin
      if (t1_term) begin
        t1_irq_q <= 1'b1;
      end else if (wr_t1_clear) begin
        t1_irq_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event capture on the rising edge of the chosen interrupt source
  logic [4:0] evt;
  logic       evt_rise;

  assign evt = t1_ctrl_q[EVT_MSB:EVT_LSB];
  // Sources 32 and 33 do not exist on the input and never fire
  assign evt_rise = (evt < 5'd30) && src_s2_q[evt + 5'd2] && !src_d_q[evt + 5'd2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_cap_q <= '0;
    end else if (clk_en && t1_ctrl_q[BIT_CAP_EN] && evt_rise) begin
      t1_cap_q <= t1_count_q;
    end
  end

  assign timer0_irq = t0_irq_q;
  assign timer1_irq = t1_irq_q;
endmodule

/* test/gp_timers_properties.sv */
// Port-level checks for the timer block
`timescale 1ns/10ps
module gp_timers_chk
  import gp_timers_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        timer0_irq,
  input wire logic        timer1_irq
);
  logic take;
  logic take_rd;
  logic clr0_q;
  logic clr1_q;
  logic ctl0_q;
  logic en0_q;
  assign take = clk_en && hsel && hready && htrans[1];
  assign take_rd = take && !hwrite;
  // Data-phase flags, so effects are tied to the edge ending the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr0_q <= 1'b0;
      clr1_q <= 1'b0;
      ctl0_q <= 1'b0;
      en0_q  <= 1'b0;
    end else if (clk_en) begin
      clr0_q <= take && hwrite && haddr[7:0] == OFS_T0_CLEAR;
      clr1_q <= take && hwrite && haddr[7:0] == OFS_T1_CLEAR;
      ctl0_q <= take && hwrite && haddr[7:0] == OFS_T0_CONTROL;
      if (ctl0_q) en0_q <= hwdata[BIT_ENABLE];
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [7:0] a); take_rd && haddr[7:0] == a; endsequence
  sequence s_rd_gap; take_rd && haddr[7:0] > OFS_STATUS; endsequence
  property p_bus_ok; hreadyout && !hresp; endproperty
  property p_hold; $changed(hrdata) |-> $past(take_rd); endproperty
  property p_t0_rsv; s_rd(OFS_T0_CONTROL) |=> (hrdata & ~T0_CTRL_MASK) == 32'h0; endproperty
  property p_t1_rsv; s_rd(OFS_T1_CONTROL) |=> (hrdata & ~T1_CTRL_MASK) == 32'h0; endproperty
  property p_t0_cnt; s_rd(OFS_T0_COUNT) |=> hrdata[31:16] == 16'h0; endproperty
  property p_gap; s_rd_gap |=> hrdata == 32'h0; endproperty
  property p_clr0; $fell(timer0_irq) |-> $past(clr0_q); endproperty
  property p_clr1; $fell(timer1_irq) |-> $past(clr1_q); endproperty
  property p_en0; $rose(timer0_irq) |-> $past(en0_q); endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus answer not zero-wait OKAY");
  a_hold: assert property (p_hold)
    else $error("read data changed without a read");
  a_t0_rsv: assert property (p_t0_rsv)
    else $error("timer0 control reserved bits set");
  a_t1_rsv: assert property (p_t1_rsv)
    else $error("timer1 control reserved bits set");
  a_t0_cnt: assert property (p_t0_cnt)
    else $error("timer0 count wider than 16 bits");
  a_gap: assert property (p_gap)
    else $error("unmapped read not zero");
  a_clr0: assert property (p_clr0)
    else $error("timer0 irq fell without clear");
  a_clr1: assert property (p_clr1)
    else $error("timer1 irq fell without clear");
  a_en0: assert property (p_en0)
    else $error("timer0 irq rose while disabled");
endmodule
bind gp_timers gp_timers_chk u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .timer0_irq(timer0_irq), .timer1_irq(timer1_irq));

/* test/tb_top.sv */
// Self-checking bench for the two general purpose timers
`timescale 1ns/10ps
module tb_top;
  import gp_timers_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        osc_32k = 1'b0, ext_clock_pin_a = 1'b0, ext_clock_pin_b = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, irq_sources = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, timer0_irq, timer1_irq;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  gp_timers dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_32k(osc_32k),
    .ext_clock_pin_a(ext_clock_pin_a), .ext_clock_pin_b(ext_clock_pin_b),
    .irq_sources(irq_sources), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq)
  );
  always #10 hclk = ~hclk;
  // Slow sources at fixed cycle ratios, so tick periods are exact
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 4) ext_clock_pin_a <= ~ext_clock_pin_a;
    if (cyc % 8 == 7) ext_clock_pin_b <= ~ext_clock_pin_b;
    if (cyc % 20 == 19) osc_32k <= ~osc_32k;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] ad, logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] wd);
    xfer(1'b1, ad, wd);
  endtask
  task automatic rdc(logic [7:0] ad, logic [31:0] exp);
    xfer(1'b0, ad, 32'h0);
    check(rd, exp);
  endtask
  // Waits for a fresh rise, so a stale pending flag is never counted
  task automatic wait_irq(bit t, output int at);
    int k;
    k = 0;
    while ((t ? timer1_irq : timer0_irq) === 1'b1 && k < 70000) begin
      @(posedge hclk);
      k++;
    end
    while ((t ? timer1_irq : timer0_irq) !== 1'b1 && k < 70000) begin
      @(posedge hclk);
      k++;
    end
    check(32'(k < 70000), 32'h1);
    at = cyc;
  endtask
  task automatic period(bit t, logic [31:0] ctl, int exp);
    int t1, t2;
    wr(t ? OFS_T1_CONTROL : OFS_T0_CONTROL, ctl);
    wr(t ? OFS_T1_CLEAR : OFS_T0_CLEAR, 32'h0);
    wait_irq(t, t1);
    wr(t ? OFS_T1_CLEAR : OFS_T0_CLEAR, 32'hff);
    wait_irq(t, t2);
    check(32'(t2 - t1), 32'(exp));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0]  ad[9] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h40};
    logic [31:0] ex[9] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0,
                           32'h0};
    logic [7:0]  wa[5] = '{OFS_T0_COUNT, OFS_T0_CONTROL, OFS_T1_CONTROL, OFS_T0_RELOAD,
                           OFS_T1_COUNT};
    logic [31:0] wd[5] = '{32'h0, 32'hffffff7f, 32'hffffff7f, 32'hffffffff, 32'h0};
    logic [31:0] we[5] = '{32'hffff, 32'h4c, 32'h3ff7f, 32'hffff, 32'hffffffff};
    for (int i = 0; i < 9; i++) rdc(ad[i], ex[i]);
    for (int i = 0; i < 5; i++) begin
      wr(wa[i], wd[i]);
      rdc(wa[i], we[i]);
    end
    wr(OFS_T0_CONTROL, 32'h0);
    wr(OFS_T1_CONTROL, 32'h0);
    check(32'(timer0_irq), 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_timer0;
    int dv[4] = '{1, 16, 256, 1};
    logic [31:0] c;
    wr(OFS_T0_RELOAD, 32'hf);
    for (int i = 0; i < 4; i++) period(1'b0, 32'hc0 | (i << 2), 16 * dv[i]);
    wr(OFS_T0_CONTROL, 32'h0);
    wr(OFS_T0_CLEAR, 32'h0);
    xfer(1'b0, OFS_T0_COUNT, 32'h0);
    c = rd;
    repeat (300) @(posedge hclk);
    rdc(OFS_T0_COUNT, c);
    check(32'(timer0_irq), 32'h0);
    $display("t_timer0 done");
  endtask
  task automatic t_timer1;
    int t;
    wr(OFS_T1_RELOAD, 32'hfffffff0);
    period(1'b1, 32'h1c0, 16);
    period(1'b1, 32'h1c4, 256);
    wr(OFS_T1_CONTROL, 32'h180);
    wr(OFS_T1_CLEAR, 32'h0);
    wait_irq(1'b1, t);
    xfer(1'b0, OFS_T1_COUNT, 32'h0);
    check(32'(rd < 32'h10), 32'h1);
    wr(OFS_T1_RELOAD, 32'h7);
    period(1'b1, 32'hc0, 8);
    period(1'b1, 32'hc8, 2048);
    period(1'b1, 32'h2c0, 320);
    period(1'b1, 32'h4c0, 80);
    period(1'b1, 32'h6c0, 128);
    wr(OFS_T1_RELOAD, 32'h100);
    period(1'b1, 32'he0, 101);
    period(1'b1, 32'hf0, 101);
    period(1'b1, 32'hc0, 257);
    $display("t_timer1 done");
  endtask
  task automatic t_capture;
    logic [31:0] c;
    wr(OFS_T1_CONTROL, 32'h230c8);
    xfer(1'b0, OFS_T1_CAPTURE, 32'h0);
    c = rd;
    irq_sources[4] <= 1'b1;
    repeat (8) @(posedge hclk);
    rdc(OFS_T1_CAPTURE, c);
    xfer(1'b0, OFS_T1_COUNT, 32'h0);
    c = rd;
    irq_sources[5] <= 1'b1;
    repeat (8) @(posedge hclk);
    xfer(1'b0, OFS_T1_CAPTURE, 32'h0);
    check(32'(rd === c || rd === c - 32'h1), 32'h1);
    // Clock enable low must freeze the count: two ticks land before the freeze
    wr(OFS_T1_CONTROL, 32'h1c0);
    xfer(1'b0, OFS_T1_COUNT, 32'h0);
    c = rd;
    clk_en <= 1'b0;
    repeat (50) @(posedge hclk);
    clk_en <= 1'b1;
    rdc(OFS_T1_COUNT, c + 32'h2);
    $display("t_capture done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_timer0;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_timer1;
    t_capture;
    final_report;
  end
  initial begin
    repeat (95000) @(posedge hclk);
    n_mismatch++;
    final_report;
  end
endmodule
